// ===== logic/dynamic_fan_threshold_loop.v
// Dynamic fan-start threshold loop for three temperature channels
//
// What this block does
// - Fan 3 floor bit: off or minimum
// - Fan 2 floor bit: off or minimum
// - Fan 1 floor bit: off or minimum
// - Three 8-bit target temperature registers
// - Above target lowers threshold, below low limit raises
// - Below low limit raises threshold
// - Flag event when below low limit
// - Above high limit lowers threshold
// - Flag event when above high limit
// - Six 8-bit low and high limits
// - Short cycle every n, long every 2n
// - Cycle code set per channel
// - Cycle code bit positions in controls
// - Code selects 8 doubling to 1024
// - Below target minus hysteresis: no short-cycle drop
// - Never below low limit: no raise
// - No adjustment keeps threshold as is
// - 4-bit hysteresis per channel
// - Short cycle lowers by twice rise
// - Long cycle lowers one above target
// - Threshold clamped to high limit on each monitor tick
`timescale 1ns/1ps
`include "fan_threshold_map.vh"

module dynamic_fan_threshold_loop #(
	parameter [7:0] INIT_THRESHOLD = 8'h5a
) (
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// Register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// Measurement side
	input wire monitor_tick,
	input wire [7:0] temp_remote1,
	input wire [7:0] temp_local,
	input wire [7:0] temp_remote2,
	input wire [3:0] hyst_remote1,
	input wire [3:0] hyst_local,
	input wire [3:0] hyst_remote2,
	// Duty requests from the fan curve
	input wire [7:0] duty_1,
	input wire [7:0] duty_2,
	input wire [7:0] duty_3,
	input wire [7:0] min_duty_1,
	input wire [7:0] min_duty_2,
	input wire [7:0] min_duty_3,
	// Fan drive and thresholds
	output reg [7:0] fan_drive_1,
	output reg [7:0] fan_drive_2,
	output reg [7:0] fan_drive_3,
	output reg [7:0] thr_remote1,
	output reg [7:0] thr_local,
	output reg [7:0] thr_remote2,
	// Limit events
	output reg [2:0] low_event,
	output reg [2:0] high_event
);

////////////////////////////////////////////////////////////////////////////
// Storage

// Index 0 is remote 1, 1 the local channel and 2 remote 2
reg [7:0] target_q [0:2];
reg [7:0] low_q [0:2];
reg [7:0] high_q [0:2];
reg [7:0] thr_q [0:2];
reg [7:0] prev_q [0:2];
reg [10:0] cnt_q [0:2];
reg [7:0] ctrl_a_q;
reg [7:0] ctrl_b_q;
reg [7:0] floor_q;

wire [7:0] temp_w [0:2];
wire [3:0] hyst_w [0:2];
wire [2:0] code_w [0:2];

assign temp_w[0] = temp_remote1;
assign temp_w[1] = temp_local;
assign temp_w[2] = temp_remote2;
assign hyst_w[0] = hyst_remote1;
assign hyst_w[1] = hyst_local;
assign hyst_w[2] = hyst_remote2;

// Each channel has its own cycle code
assign code_w[0] = ctrl_b_q[`REMOTE1_CODE_HI:`REMOTE1_CODE_LO];
assign code_w[1] = ctrl_b_q[`LOCAL_CODE_HI:`LOCAL_CODE_LO];
// Bit 0 of control a is the low bit of the remote 2 code
assign code_w[2] = {ctrl_b_q[`REMOTE2_CODE_B_HI:`REMOTE2_CODE_B_LO],
	ctrl_a_q[`REMOTE2_CODE_A_BIT]};

////////////////////////////////////////////////////////////////////////////
// Functions

// Short cycle length minus one, used as a wrap mask on the counter
// Code 7 gives 1024, the widest short cycle
function [10:0] short_mask;
	input [2:0] code;
	begin
		short_mask = (`SHORT_BASE_CYCLES << code) - 11'h001;
	end
endfunction

// Long cycle is always twice the short one
function [10:0] long_mask;
	input [2:0] code;
	reg [10:0] s;
	begin
		// One more mask bit; a shift by code plus one would wrap at code 7
		s = short_mask(code);
		long_mask = {s[9:0], 1'b1};
	end
endfunction

// Next threshold; arithmetic is 10 bits wide so nothing wraps
function [7:0] next_thr;
	input [7:0] thr;
	input [7:0] t;
	input [7:0] prev;
	input [7:0] tgt;
	input [3:0] hyst;
	input [7:0] lo;
	input [7:0] hi;
	input do_short;
	input do_long;
	reg [9:0] v;
	reg [9:0] dec;
	begin
		v = {2'h0, thr};
		dec = 10'h000;
		// Only a rise above target minus hysteresis counts on short cycles
		if (do_short && ({2'h0, t} + {6'h00, hyst} > {2'h0, tgt})
			&& t > prev)
			dec = {1'b0, t - prev, 1'b0};
		if (do_long && (t > tgt || t > hi))
			dec = dec + 10'h001;
		// Floor at zero keeps a large drop from wrapping round and being clamped to the high limit
		if (dec > v)
			v = 10'h000;
		else
			v = v - dec;
		// Raise only while above threshold and below low limit
		// A long cycle that lowers the threshold never also raises it
		if (do_long && dec == 10'h000 && t < lo && t > thr
			&& thr < hi && thr < tgt)
			v = v + 10'h001;
		if (v > {2'h0, hi})
			v = {2'h0, hi};
		next_thr = v[7:0];
	end
endfunction

// Below threshold minus hysteresis the fan is off or at its floor
function [7:0] drive;
	input [7:0] t;
	input [7:0] thr;
	input [3:0] hyst;
	input keep;
	input [7:0] duty;
	input [7:0] min_duty;
	begin
		if ({2'h0, t} + {6'h00, hyst} < {2'h0, thr})
			drive = keep ? min_duty : `FAN_OFF_DUTY;
		else
			drive = duty;
	end
endfunction

////////////////////////////////////////////////////////////////////////////
// Register writes

integer i;

always @(posedge clock)
begin
	if (!rst_n)
	begin
		for (i = 0; i < 3; i = i + 1)
		begin
			target_q[i] <= `RST_TARGET;
			low_q[i] <= `RST_LOW_LIMIT;
			high_q[i] <= `RST_HIGH_LIMIT;
		end
		ctrl_a_q <= `RST_CONTROL;
		ctrl_b_q <= `RST_CONTROL;
		floor_q <= `RST_FAN_FLOOR;
	end
	else if (reg_wr)
	begin
		case (reg_addr)
		`ADDR_REMOTE1_TARGET: target_q[0] <= reg_wdata;
		`ADDR_LOCAL_TARGET: target_q[1] <= reg_wdata;
		`ADDR_REMOTE2_TARGET: target_q[2] <= reg_wdata;
		`ADDR_LOOP_CONTROL_A: ctrl_a_q <= reg_wdata;
		`ADDR_LOOP_CONTROL_B: ctrl_b_q <= reg_wdata;
		`ADDR_REMOTE1_LOW: low_q[0] <= reg_wdata;
		`ADDR_REMOTE1_HIGH: high_q[0] <= reg_wdata;
		`ADDR_LOCAL_LOW: low_q[1] <= reg_wdata;
		`ADDR_LOCAL_HIGH: high_q[1] <= reg_wdata;
		`ADDR_REMOTE2_LOW: low_q[2] <= reg_wdata;
		`ADDR_REMOTE2_HIGH: high_q[2] <= reg_wdata;
		`ADDR_FAN_FLOOR: floor_q <= reg_wdata;
		default: ;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////
// Register reads; unmapped addresses read zero
// A read and a write in one cycle return the old contents

always @(posedge clock)
begin
	if (!rst_n)
		reg_rdata <= `RST_RDATA;
	else if (reg_rd)
	begin
		case (reg_addr)
		`ADDR_REMOTE1_TARGET: reg_rdata <= target_q[0];
		`ADDR_LOCAL_TARGET: reg_rdata <= target_q[1];
		`ADDR_REMOTE2_TARGET: reg_rdata <= target_q[2];
		`ADDR_LOOP_CONTROL_A: reg_rdata <= ctrl_a_q;
		`ADDR_LOOP_CONTROL_B: reg_rdata <= ctrl_b_q;
		`ADDR_REMOTE1_LOW: reg_rdata <= low_q[0];
		`ADDR_REMOTE1_HIGH: reg_rdata <= high_q[0];
		`ADDR_LOCAL_LOW: reg_rdata <= low_q[1];
		`ADDR_LOCAL_HIGH: reg_rdata <= high_q[1];
		`ADDR_REMOTE2_LOW: reg_rdata <= low_q[2];
		`ADDR_REMOTE2_HIGH: reg_rdata <= high_q[2];
		`ADDR_FAN_FLOOR: reg_rdata <= floor_q;
		default: reg_rdata <= 8'h00;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////
// Cycle counters and threshold loop

reg [10:0] cnt_d [0:2];
reg [7:0] thr_d [0:2];
reg [7:0] prev_d [0:2];
reg short_hit [0:2];
reg long_hit [0:2];
integer k;
integer j;

// Next state is worked out apart from the flops so that the clocked
// process below holds nothing but non-blocking copies
always @*
begin
	for (k = 0; k < 3; k = k + 1)
	begin
		// Counter wraps at 2048, a multiple of every cycle length
		cnt_d[k] = cnt_q[k] + 11'h001;
		short_hit[k] = (cnt_d[k] & short_mask(code_w[k]))
			== 11'h000;
		long_hit[k] = (cnt_d[k] & long_mask(code_w[k]))
			== 11'h000;
		thr_d[k] = next_thr(thr_q[k], temp_w[k], prev_q[k],
			target_q[k], hyst_w[k], low_q[k], high_q[k],
			short_hit[k], long_hit[k]);
		// The previous sample moves on short cycles only
		if (short_hit[k])
			prev_d[k] = temp_w[k];
		else
			prev_d[k] = prev_q[k];
	end
end

always @(posedge clock)
begin
	if (!rst_n)
	begin
		for (j = 0; j < 3; j = j + 1)
		begin
			cnt_q[j] <= `RST_COUNT;
			thr_q[j] <= INIT_THRESHOLD;
			prev_q[j] <= `RST_PREV;
		end
	end
	else if (monitor_tick)
	begin
		for (j = 0; j < 3; j = j + 1)
		begin
			cnt_q[j] <= cnt_d[j];
			thr_q[j] <= thr_d[j];
			prev_q[j] <= prev_d[j];
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// Outputs

integer m;

// Thresholds leave one cycle after they change inside, in step with the
// fan decision that used them
always @(posedge clock)
begin
	if (!rst_n)
	begin
		fan_drive_1 <= `FAN_OFF_DUTY;
		fan_drive_2 <= `FAN_OFF_DUTY;
		fan_drive_3 <= `FAN_OFF_DUTY;
		thr_remote1 <= INIT_THRESHOLD;
		thr_local <= INIT_THRESHOLD;
		thr_remote2 <= INIT_THRESHOLD;
		low_event <= 3'h0;
		high_event <= 3'h0;
	end
	else
	begin
		fan_drive_1 <= drive(temp_w[0], thr_q[0], hyst_w[0],
			floor_q[`FAN1_KEEP_BIT], duty_1, min_duty_1);
		fan_drive_2 <= drive(temp_w[1], thr_q[1], hyst_w[1],
			floor_q[`FAN2_KEEP_BIT], duty_2, min_duty_2);
		fan_drive_3 <= drive(temp_w[2], thr_q[2], hyst_w[2],
			floor_q[`FAN3_KEEP_BIT], duty_3, min_duty_3);
		thr_remote1 <= thr_q[0];
		thr_local <= thr_q[1];
		thr_remote2 <= thr_q[2];
		for (m = 0; m < 3; m = m + 1)
		begin
			low_event[m] <= temp_w[m] < low_q[m];
			high_event[m] <= temp_w[m] > high_q[m];
		end
	end
end

// Hysteresis is taken as given; a zero value puts the on and off points
// together, so a fan may chatter at its threshold
endmodule // dynamic_fan_threshold_loop

// ===== logic/fan_threshold_map.vh
// Register map, reset values and field positions of the fan threshold loop
`ifndef FAN_THRESHOLD_MAP_VH
`define FAN_THRESHOLD_MAP_VH

`define ADDR_REMOTE1_TARGET 8'h33
`define ADDR_LOCAL_TARGET 8'h34
`define ADDR_REMOTE2_TARGET 8'h35
`define ADDR_LOOP_CONTROL_A 8'h36
`define ADDR_LOOP_CONTROL_B 8'h37
`define ADDR_REMOTE1_LOW 8'h4e
`define ADDR_REMOTE1_HIGH 8'h4f
`define ADDR_LOCAL_LOW 8'h50
`define ADDR_LOCAL_HIGH 8'h51
`define ADDR_REMOTE2_LOW 8'h52
`define ADDR_REMOTE2_HIGH 8'h53
`define ADDR_FAN_FLOOR 8'h62

`define RST_TARGET 8'ha4
`define RST_LOW_LIMIT 8'h01
`define RST_HIGH_LIMIT 8'h7f
`define RST_CONTROL 8'h00
`define RST_FAN_FLOOR 8'h00
`define RST_COUNT 11'h000
`define RST_PREV 8'h00
`define RST_RDATA 8'h00
`define FAN_OFF_DUTY 8'h00

`define REMOTE1_CODE_HI 2
`define REMOTE1_CODE_LO 0
`define LOCAL_CODE_HI 5
`define LOCAL_CODE_LO 3
`define REMOTE2_CODE_B_HI 7
`define REMOTE2_CODE_B_LO 6
`define REMOTE2_CODE_A_BIT 0
`define FAN1_KEEP_BIT 5
`define FAN2_KEEP_BIT 6
`define FAN3_KEEP_BIT 7

`define SHORT_BASE_CYCLES 11'h008
`define CYCLE_COUNT_WIDTH 11
`define CH_REMOTE1 2'h0
`define CH_LOCAL 2'h1
`define CH_REMOTE2 2'h2

`endif

// ===== test/fan_loop_sva.sv
// Port assertions of the dynamic fan threshold loop
`timescale 1ns/1ps
module fan_loop_sva (
	input wire clock,
	input wire rst_n,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire monitor_tick,
	input wire [7:0] temp_remote1,
	input wire [3:0] hyst_remote1,
	input wire [7:0] duty_1,
	input wire [7:0] min_duty_1,
	input wire [7:0] fan_drive_1,
	input wire [7:0] thr_remote1
);
	reg [8:0] heat_q;
	reg [1:0] live_q;
	// Heat of the last cycle meets the threshold copy, both one cycle late
	always @(posedge clock)
	begin
		heat_q <= {1'b0, temp_remote1} + {5'h00, hyst_remote1};
		live_q <= {live_q[0], rst_n};
	end
	////////////////////////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence wr_target; reg_wr && reg_addr == 8'h33; endsequence
	sequence rd_target; reg_rd && reg_addr == 8'h33; endsequence
	a_reset_state: assert property (disable iff (1'b0)
		!rst_n |=> thr_remote1 == 8'h5a && reg_rdata == 8'h00)
		else $error("reset state wrong");
	a_thr_on_tick: assert property ($changed(thr_remote1)
		|-> $past(monitor_tick, 2)) else $error("threshold moved untimed");
	a_idle_hold: assert property (!monitor_tick [*2]
		|=> $stable(thr_remote1)) else $error("threshold moved idle");
	a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h40
		|=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved");
	a_write_read: assert property (wr_target ##1 rd_target
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("readback");
	a_fan_hot: assert property (&live_q && heat_q >= thr_remote1
		|-> fan_drive_1 == $past(duty_1)) else $error("fan 1 duty");
	a_fan_cold: assert property (&live_q && heat_q < thr_remote1
		|-> fan_drive_1 == 8'h00 || fan_drive_1 == $past(min_duty_1))
		else $error("fan 1 floor");
endmodule // fan_loop_sva
bind dynamic_fan_threshold_loop fan_loop_sva chk (.clock(clock),
	.rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.monitor_tick(monitor_tick), .temp_remote1(temp_remote1),
	.hyst_remote1(hyst_remote1), .duty_1(duty_1), .min_duty_1(min_duty_1),
	.fan_drive_1(fan_drive_1), .thr_remote1(thr_remote1));

// ===== test/fan_model.sv
// Fan model: three fans fed by the duty outputs of the loop
`timescale 1ns/1ps
module fan_model (
	// Duty from the block
	input wire [7:0] drive_1,
	input wire [7:0] drive_2,
	input wire [7:0] drive_3,
	// Rotor state
	output wire [2:0] spinning
);
	// Zero duty stops a rotor; any other duty keeps it turning
	assign spinning = {|drive_3, |drive_2, |drive_1};
endmodule // fan_model

// ===== test/tb_dynamic_fan_threshold_loop.sv
// Self-checking bench of the dynamic fan threshold loop
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
	num_errors++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_dynamic_fan_threshold_loop;
	logic clock = 0;
	logic rst_n = 0;
	logic reg_wr = 0, reg_rd = 0, monitor_tick = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, du = 8'hc0, mn = 8'h20;
	logic [7:0] t1 = 40, t2 = 40, t3 = 40, reg_rdata, d1, d2, d3;
	logic [7:0] thr1, thr2, thr3;
	logic [3:0] h1 = 4, h2 = 4, h3 = 4;
	logic [2:0] low_event, high_event, spinning;
	int num_errors = 0;
	int comparisons = 0;
	logic [7:0] ra [12] = '{8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h4e,
		8'h4f, 8'h50, 8'h51, 8'h52, 8'h53, 8'h62};
	logic [7:0] rv [12] = '{8'ha4, 8'ha4, 8'ha4, 8'h00, 8'h00, 8'h01,
		8'h7f, 8'h01, 8'h7f, 8'h01, 8'h7f, 8'h00};
	dynamic_fan_threshold_loop dut (.clock(clock), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .monitor_tick(monitor_tick),
		.temp_remote1(t1), .temp_local(t2), .temp_remote2(t3),
		.hyst_remote1(h1), .hyst_local(h2), .hyst_remote2(h3),
		.duty_1(du), .duty_2(du ^ 8'h02), .duty_3(du ^ 8'h03),
		.min_duty_1(mn), .min_duty_2(mn ^ 8'h02), .min_duty_3(mn ^ 8'h03),
		.fan_drive_1(d1), .fan_drive_2(d2), .fan_drive_3(d3),
		.thr_remote1(thr1), .thr_local(thr2), .thr_remote2(thr3),
		.low_event(low_event), .high_event(high_event));
	fan_model fans (.drive_1(d1), .drive_2(d2), .drive_3(d3),
		.spinning(spinning));
	initial
	begin
		forever #2.5 clock = ~clock;
	end
	////////////////////////////////////////////////////////////
	task wr(input [7:0] a, input [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge clock);
		reg_wr = 0;
	endtask
	// No leading wait, so a read may follow a write back to back
	task rd(input [7:0] a, input [7:0] e);
		reg_addr = a;
		reg_rd = 1;
		@(negedge clock);
		reg_rd = 0;
		`CHK("rdata", e, reg_rdata)
		@(negedge clock);
	endtask
	// Last wait lets the one-cycle-late threshold copy land
	task tick(input int n);
		repeat (n)
		begin
			@(negedge clock);
			monitor_tick = 1;
			@(negedge clock);
			monitor_tick = 0;
		end
		@(negedge clock);
	endtask
	task chk_thr(input [7:0] e1, input [7:0] e2, input [7:0] e3);
		`CHK("thr1", e1, thr1)
		`CHK("thr2", e2, thr2)
		`CHK("thr3", e3, thr3)
	endtask
	task chk_fans(input [7:0] e1, input [7:0] e2, input [7:0] e3);
		`CHK("fan1", e1, d1)
		`CHK("fan2", e2, d2)
		`CHK("fan3", e3, d3)
		`CHK("spin", {|e3, |e2, |e1}, spinning)
	endtask
	////////////////////////////////////////////////////////////
	task reset_values;
		chk_thr(8'h5a, 8'h5a, 8'h5a);
		for (int i = 0; i < 12; i++) rd(ra[i], rv[i]);
	endtask
	// Codes: remote1 0, local 1, remote2 2 split over both controls
	task short_cycles;
		wr(8'h37, 8'h48);
		wr(8'h33, 8'd42);
		wr(8'h34, 8'd42);
		tick(7);
		chk_thr(8'h5a, 8'h5a, 8'h5a);
		tick(1);
		chk_thr(8'd10, 8'h5a, 8'h5a);
		t1 = 41;
		tick(8);
		chk_thr(8'd8, 8'd10, 8'h5a);
	endtask
	task long_cycles;
		t1 = 43;
		tick(16);
		chk_thr(8'd3, 8'd10, 8'h5a);
	endtask
	task limits;
		wr(8'h50, 8'd50);
		wr(8'h4f, 8'd40);
		tick(32);
		chk_thr(8'd1, 8'd11, 8'h5a);
		`CHK("low", 3'b010, low_event)
		`CHK("high", 3'b001, high_event)
	endtask
	task fan_floor;
		chk_fans(du, du ^ 8'h02, 8'h00);
		t1 = 0;
		t2 = 0;
		h1 = 0;
		h2 = 0;
		wr(8'h62, 8'he0);
		@(negedge clock);
		chk_fans(mn, mn ^ 8'h02, mn ^ 8'h03);
		wr(8'h62, 8'h00);
		@(negedge clock);
		chk_fans(8'h00, 8'h00, 8'h00);
	endtask
	// Code 7 on remote 2: nothing may fire before count 1024
	task slow_code;
		wr(8'h36, 8'h01);
		wr(8'h37, 8'hc8);
		wr(8'h35, 8'd30);
		tick(16);
		chk_thr(8'd1, 8'd11, 8'h5a);
	endtask
	task reg_rw;
		for (int i = 0; i < 12; i++)
		begin
			wr(ra[i], ~rv[i]);
			rd(ra[i], ~rv[i]);
		end
		wr(8'h40, 8'h5c);
		rd(8'h40, 8'h00);
	endtask
	task complete_run;
		if (num_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(negedge clock);
		rst_n = 1;
		reset_values;
		short_cycles;
		long_cycles;
		limits;
		fan_floor;
		slow_code;
		reg_rw;
		complete_run;
	end
	initial
	begin
		#50000;
		num_errors++;
		complete_run;
	end
endmodule // tb_dynamic_fan_threshold_loop
